// file: src/occd_defines.vh
// Constants for the oscillator select and clock divide block
`ifndef OCCD_DEFINES_VH
`define OCCD_DEFINES_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define OCCD_ADDR_OSC_CTRL 4'h0
`define OCCD_ADDR_CLK_DIV 4'h4
`define OCCD_ADDR_UNLOCK 4'h8

// ---------------------------------------------------------------
// Unlock keys, written in order to the unlock address
// ---------------------------------------------------------------
`define OCCD_UNLOCK_KEY1 16'h0055
`define OCCD_UNLOCK_KEY2 16'h00aa

// ---------------------------------------------------------------
// Oscillator control field positions
// ---------------------------------------------------------------
`define OCCD_OC_CUR_HI 14
`define OCCD_OC_CUR_LO 12
`define OCCD_OC_NEW_HI 10
`define OCCD_OC_NEW_LO 8
`define OCCD_OC_SW_LOCK 7
`define OCCD_OC_REMAP_LOCK 6
`define OCCD_OC_PLL_LOCK 5
`define OCCD_OC_FAIL 3
`define OCCD_OC_SEC_EN 1
`define OCCD_OC_SW_REQ 0

// ---------------------------------------------------------------
// Clock divisor field positions and reset values
// ---------------------------------------------------------------
`define OCCD_CD_ROI 15
`define OCCD_CD_DOZE_HI 14
`define OCCD_CD_DOZE_LO 12
`define OCCD_CD_DOZE_EN 11
`define OCCD_CD_FRC_HI 10
`define OCCD_CD_FRC_LO 8
`define OCCD_CD_DOZE_RST 3'h3
`define OCCD_CD_FRC_RST 3'h0

// ---------------------------------------------------------------
// Source codes, primary submodes and monitor settings
// ---------------------------------------------------------------
`define OCCD_SRC_FRC_DIVN 3'h7
`define OCCD_SRC_FRC_DIV16 3'h6
`define OCCD_SRC_LOW_POWER_RC_OSC 3'h5
`define OCCD_SRC_SEC 3'h4
`define OCCD_SRC_PRI_PLL 3'h3
`define OCCD_SRC_PRI 3'h2
`define OCCD_SRC_FRC_PLL 3'h1
`define OCCD_SRC_FRC 3'h0
`define OCCD_PRI_EXT 2'h0
`define OCCD_PRI_MED_XTAL 2'h1
`define OCCD_PRI_HI_XTAL 2'h2
`define OCCD_MON_SW_ONLY 2'h1
`define OCCD_MON_SW_FAIL_SAFE_MONITOR 2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OCCD_SETTLE_TICKS 4'ha
`define OCCD_DIV16_EXP 4'h4
`define OCCD_CYCLE_EXP 4'h1
`define OCCD_FRC_MAX_EXP 4'h8

`endif

// file: src/occd_pow2_div.v
// Power-of-two tick divider used for postscaler, instruction and doze clocks
`timescale 1ns/1ps
`include "occd_defines.vh"

module occd_pow2_div
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Ticks in and out
   input wire tick_in,
   input wire [3:0] exp_in,
   input wire restart,
   output reg tick_out
);

   reg [7:0] count_reg;

   // Mask of the low counter bits for a divide by two to the exp
   function [7:0] occd_mask;
      input [3:0] e;
      begin
         occd_mask = (e >= 4'h8) ? 8'hff : ((8'h01 << e) - 8'h01);
      end
   endfunction

   // Count input ticks, emit one tick per full period
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= 8'h00;
         tick_out <= 1'b0;
      end
      else if (restart)
      begin
         count_reg <= 8'h00;
         tick_out <= 1'b0;
      end
      else if (tick_in)
      begin
         if ((count_reg & occd_mask(exp_in)) == occd_mask(exp_in))
         begin
            count_reg <= 8'h00;
            tick_out <= 1'b1;
         end
         else
         begin
            count_reg <= count_reg + 8'h01;
            tick_out <= 1'b0;
         end
      end
      else
      begin
         tick_out <= 1'b0;
      end
   end

endmodule // occd_pow2_div

// file: src/occd_clock_ctrl.v
// Oscillator source select, clock switch sequencer and clock divisor
`timescale 1ns/1ps
`include "occd_defines.vh"


module occd_clock_ctrl
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Configuration levels
   input wire [2:0] initial_source_select_cfg,
   input wire [1:0] primary_submode_cfg,
   input wire [1:0] switch_monitor_cfg,
   // Oscillator and analog pins
   input wire fast_rc_osc_pin,
   input wire low_power_rc_osc_pin,
   input wire secondary_osc_pin,
   input wire primary_osc_pin,
   input wire pll_out_pin,
   input wire pll_lock_pin,
   input wire clock_fail_pin,
   // Events from the system
   input wire irq_event,
   input wire remap_wr_req,
   // Oscillator controls
   output reg pll_enable,
   output reg pll_ref_primary,
   output reg secondary_osc_enable,
   output reg [1:0] primary_submode,
   output reg [2:0] current_source,
   output reg pin_remap_lock,
   output reg remap_wr_accept,
   // Clock ticks
   output reg fosc_tick,
   output wire cycle_tick,
   output wire cpu_tick
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_LOCKW = 3'b010;
   localparam ST_SETTLE = 3'b100;

   reg [6:0] sync1_reg;
   reg [6:0] sync2_reg;
   reg [6:0] sync3_reg;
   reg [2:0] state_reg;
   reg [3:0] settle_reg;
   reg [2:0] new_source_reg;
   reg source_switch_lock_reg;
   reg pll_lock_reg;
   reg clock_fail_flag_reg;
   reg secondary_osc_enable_reg;
   reg switch_request_reg;
   reg recover_on_interrupt_reg;
   reg [2:0] cpu_clock_reduce_reg;
   reg cpu_clock_reduce_enable_reg;
   reg [2:0] fast_rc_postscaler_reg;
   reg [1:0] unlock_reg;
   reg cfg_loaded_reg;
   reg [3:0] doze_exp_reg;
   reg commit_pulse_reg;
   reg doze_restart_reg;
   reg [3:0] doze_exp_next;
   reg [2:0] doze_field_next;
   wire [6:0] edge_w;
   wire frc_tick;
   wire frcn_tick;
   wire frc16_tick;
   wire [7:0] src_ticks;
   wire new_tick;
   wire sw_enabled;
   wire mon_enabled;
   wire sw_locked;
   wire wr_osc;
   wire wr_div;
   wire wr_unlock;
   wire fail_event;
   wire busy;

   // Source uses the PLL
   function occd_uses_pll;
      input [2:0] code;
      begin
         occd_uses_pll = (code == `OCCD_SRC_PRI_PLL) || (code == `OCCD_SRC_FRC_PLL);
      end
   endfunction

   // Postscaler code to exponent, top code gives 256
   function [3:0] occd_frc_exp;
      input [2:0] code;
      begin
         occd_frc_exp = (code == 3'h7) ? `OCCD_FRC_MAX_EXP : {1'b0, code};
      end
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   // Two flops per pin, third flop only for edge finding
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
         sync3_reg <= 7'h00;
      end
      else
      begin
         sync1_reg <= {clock_fail_pin, pll_lock_pin, pll_out_pin, primary_osc_pin,
                       secondary_osc_pin, low_power_rc_osc_pin, fast_rc_osc_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign edge_w = sync2_reg & ~sync3_reg;
   assign frc_tick = edge_w[0];
   assign fail_event = edge_w[6] & mon_enabled;

   // ---------------------------------------------------------------
   // Source tick generation
   // ---------------------------------------------------------------
   occd_pow2_div u_frc_post
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick_in(frc_tick),
      .exp_in(occd_frc_exp(fast_rc_postscaler_reg)),
      .restart(1'b0),
      .tick_out(frcn_tick)
   );

   occd_pow2_div u_frc_div16
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick_in(frc_tick),
      .exp_in(`OCCD_DIV16_EXP),
      .restart(1'b0),
      .tick_out(frc16_tick)
   );

   // Ticks ordered by source code; both PLL codes use the PLL output
   assign src_ticks = {frcn_tick, frc16_tick, edge_w[1], edge_w[2],
                       edge_w[4], edge_w[3], edge_w[4], frc_tick};
   assign new_tick = src_ticks[new_source_reg];

   // Active source tick, moves when current_source changes: on a switch commit, a fail fallback or the configuration load after reset
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         fosc_tick <= 1'b0;
      else
         fosc_tick <= src_ticks[current_source];
   end

   // Instruction and peripheral tick at half the oscillator rate
   occd_pow2_div u_cycle_div
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick_in(fosc_tick),
      .exp_in(`OCCD_CYCLE_EXP),
      .restart(commit_pulse_reg),
      .tick_out(cycle_tick)
   );

   // Processor tick, reduced from the cycle tick when enabled
   occd_pow2_div u_doze_div
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick_in(cycle_tick),
      .exp_in(doze_exp_reg),
      .restart(doze_restart_reg),
      .tick_out(cpu_tick)
   );

   // Ratio forced to 1:1 unless enabled; restart on change
   always @*
   begin
      doze_exp_next = cpu_clock_reduce_enable_reg ? {1'b0, cpu_clock_reduce_reg} : 4'h0;
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         doze_exp_reg <= 4'h0;
         doze_restart_reg <= 1'b0;
      end
      else
      begin
         doze_exp_reg <= doze_exp_next;
         doze_restart_reg <= (doze_exp_next != doze_exp_reg);
      end
   end

   // ---------------------------------------------------------------
   // Bus decode and unlock
   // ---------------------------------------------------------------
   assign sw_enabled = ~switch_monitor_cfg[1];
   assign mon_enabled = (switch_monitor_cfg == `OCCD_MON_SW_FAIL_SAFE_MONITOR);
   assign sw_locked = (switch_monitor_cfg == `OCCD_MON_SW_ONLY) & source_switch_lock_reg;
   assign wr_unlock = reg_wr & (reg_addr == `OCCD_ADDR_UNLOCK);
   assign wr_osc = reg_wr & (reg_addr == `OCCD_ADDR_OSC_CTRL) & unlock_reg[1];
   assign wr_div = reg_wr & (reg_addr == `OCCD_ADDR_CLK_DIV);
   assign busy = ~state_reg[0];

   // Two keys in a row arm one write; any other write disarms
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         unlock_reg <= 2'h0;
      else if (reg_wr)
      begin
         if (wr_unlock && reg_wdata == `OCCD_UNLOCK_KEY1)
            unlock_reg <= 2'h1;
         else if (wr_unlock && unlock_reg == 2'h1 && reg_wdata == `OCCD_UNLOCK_KEY2)
            unlock_reg <= 2'h2;
         else
            unlock_reg <= 2'h0;
      end
   end

   // Registered read data, unmapped reads give zero
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd && reg_addr == `OCCD_ADDR_OSC_CTRL)
         reg_rdata <= {1'b0, current_source, 1'b0, new_source_reg,
                       source_switch_lock_reg, pin_remap_lock, pll_lock_reg, 1'b0,
                       clock_fail_flag_reg, 1'b0, secondary_osc_enable_reg,
                       switch_request_reg};
      else if (reg_rd && reg_addr == `OCCD_ADDR_CLK_DIV)
         reg_rdata <= {recover_on_interrupt_reg, cpu_clock_reduce_reg,
                       cpu_clock_reduce_enable_reg, fast_rc_postscaler_reg, 8'h00};
      else
         reg_rdata <= 16'h0000;
   end

   // ---------------------------------------------------------------
   // Clock divisor register
   // ---------------------------------------------------------------
   always @*
   begin
      doze_field_next = cpu_clock_reduce_enable_reg ? cpu_clock_reduce_reg :
                        reg_wdata[`OCCD_CD_DOZE_HI:`OCCD_CD_DOZE_LO];
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         recover_on_interrupt_reg <= 1'b0;
         cpu_clock_reduce_reg <= `OCCD_CD_DOZE_RST;
         cpu_clock_reduce_enable_reg <= 1'b0;
         fast_rc_postscaler_reg <= `OCCD_CD_FRC_RST;
      end
      else
      begin
         if (wr_div)
         begin
            recover_on_interrupt_reg <= reg_wdata[`OCCD_CD_ROI];
            cpu_clock_reduce_reg <= doze_field_next;
            fast_rc_postscaler_reg <= reg_wdata[`OCCD_CD_FRC_HI:`OCCD_CD_FRC_LO];
         end
         // Interrupt recovery beats a software set in the same cycle
         if (irq_event && recover_on_interrupt_reg)
            cpu_clock_reduce_enable_reg <= 1'b0;
         else if (wr_div)
            cpu_clock_reduce_enable_reg <= reg_wdata[`OCCD_CD_DOZE_EN] &
                                           (doze_field_next != 3'h0);
      end
   end

   // ---------------------------------------------------------------
   // Oscillator control register and switch sequencer
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         settle_reg <= 4'h0;
         current_source <= `OCCD_SRC_FRC_DIVN;
         new_source_reg <= `OCCD_SRC_FRC_DIVN;
         primary_submode <= `OCCD_PRI_EXT;
         cfg_loaded_reg <= 1'b0;
         source_switch_lock_reg <= 1'b0;
         pin_remap_lock <= 1'b0;
         pll_lock_reg <= 1'b0;
         clock_fail_flag_reg <= 1'b0;
         secondary_osc_enable_reg <= 1'b0;
         switch_request_reg <= 1'b0;
         commit_pulse_reg <= 1'b0;
      end
      else if (!cfg_loaded_reg)
      begin
         // Configuration caught once after reset release
         cfg_loaded_reg <= 1'b1;
         current_source <= initial_source_select_cfg;
         new_source_reg <= initial_source_select_cfg;
         primary_submode <= primary_submode_cfg;
      end
      else
      begin
         commit_pulse_reg <= 1'b0;
         pll_lock_reg <= sync2_reg[5] & pll_enable;
         if (wr_osc)
         begin
            new_source_reg <= reg_wdata[`OCCD_OC_NEW_HI:`OCCD_OC_NEW_LO];
            source_switch_lock_reg <= reg_wdata[`OCCD_OC_SW_LOCK];
            pin_remap_lock <= reg_wdata[`OCCD_OC_REMAP_LOCK];
            secondary_osc_enable_reg <= reg_wdata[`OCCD_OC_SEC_EN];
            if (!reg_wdata[`OCCD_OC_FAIL])
               clock_fail_flag_reg <= 1'b0;
            if (reg_wdata[`OCCD_OC_SW_REQ] && sw_enabled && !sw_locked && !busy)
               switch_request_reg <= 1'b1;
         end
         if (fail_event)
         begin
            // Monitor falls back to fast RC, keeping the PLL if in use
            clock_fail_flag_reg <= 1'b1;
            current_source <= occd_uses_pll(current_source) ?
                              `OCCD_SRC_FRC_PLL : `OCCD_SRC_FRC;
            commit_pulse_reg <= 1'b1;
            switch_request_reg <= 1'b0;
            state_reg <= ST_IDLE;
         end
         else
         begin
            case (state_reg)
               ST_IDLE:
               begin
                  settle_reg <= 4'h0;
                  if (switch_request_reg)
                  begin
                     if (new_source_reg == current_source)
                        switch_request_reg <= 1'b0;
                     else
                     begin
                        pll_lock_reg <= 1'b0;
                        clock_fail_flag_reg <= 1'b0;
                        state_reg <= occd_uses_pll(new_source_reg) ? ST_LOCKW : ST_SETTLE;
                     end
                  end
               end
               ST_LOCKW:
               begin
                  if (pll_lock_reg)
                     state_reg <= ST_SETTLE;
               end
               ST_SETTLE:
               begin
                  if (new_tick)
                  begin
                     if (settle_reg == `OCCD_SETTLE_TICKS - 4'h1)
                     begin
                        current_source <= new_source_reg;
                        switch_request_reg <= 1'b0;
                        commit_pulse_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                     end
                     else
                        settle_reg <= settle_reg + 4'h1;
                  end
               end
               default:
                  state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Oscillator enables and pin remap gate
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pll_enable <= 1'b0;
         pll_ref_primary <= 1'b0;
         secondary_osc_enable <= 1'b0;
         remap_wr_accept <= 1'b0;
      end
      else
      begin
         pll_enable <= occd_uses_pll(current_source) |
                       (busy & occd_uses_pll(new_source_reg));
         pll_ref_primary <= busy ? (new_source_reg == `OCCD_SRC_PRI_PLL) :
                            (current_source == `OCCD_SRC_PRI_PLL);
         secondary_osc_enable <= secondary_osc_enable_reg |
                                 (current_source == `OCCD_SRC_SEC) |
                                 (busy & (new_source_reg == `OCCD_SRC_SEC));
         remap_wr_accept <= remap_wr_req & ~pin_remap_lock;
      end
   end

endmodule // occd_clock_ctrl

// file: dv/occd_clock_ctrl_assertions.sv
// Port checker for the clock control block
`timescale 1ns/1ps

module occd_chk
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Observed ports
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire remap_wr_req,
   input wire remap_wr_accept,
   input wire pin_remap_lock,
   input wire [2:0] current_source,
   input wire pll_enable,
   input wire pll_ref_primary,
   input wire fosc_tick,
   input wire cycle_tick,
   input wire cpu_tick
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Remap write attempts with the lock open or shut
   sequence s_open_req;
      remap_wr_req && !pin_remap_lock;
   endsequence
   sequence s_shut_req;
      remap_wr_req && pin_remap_lock;
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   rst_src_a: assert property ($rose(rst_n) |-> current_source == 3'h7)
      else $error("source not fast rc divide-by-n after reset");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   remap_ok_a: assert property (s_open_req |=> remap_wr_accept)
      else $error("remap write not accepted while open");
   remap_block_a: assert property (s_shut_req |=> !remap_wr_accept)
      else $error("remap write accepted while locked");
   pll_pri_a: assert property (current_source == 3'h3 |-> pll_enable && pll_ref_primary)
      else $error("primary pll mode without pll on primary");
   cyc_half_a: assert property (cycle_tick |-> $past(fosc_tick))
      else $error("cycle tick without a source tick");
   cyc_space_a: assert property (cycle_tick |=> !cycle_tick [*3])
      else $error("cycle ticks too close");
   fosc_pulse_a: assert property (fosc_tick |=> !fosc_tick)
      else $error("source tick longer than one cycle");
   cpu_src_a: assert property (cpu_tick |-> $past(cycle_tick))
      else $error("processor tick without a cycle tick");
endmodule // occd_chk

bind occd_clock_ctrl occd_chk i_occd_chk
(
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .remap_wr_req(remap_wr_req),
   .remap_wr_accept(remap_wr_accept),
   .pin_remap_lock(pin_remap_lock),
   .current_source(current_source),
   .pll_enable(pll_enable),
   .pll_ref_primary(pll_ref_primary),
   .fosc_tick(fosc_tick),
   .cycle_tick(cycle_tick),
   .cpu_tick(cpu_tick)
);

// file: dv/tb.sv
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
`include "occd_defines.vh"

module tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [15:0] reg_wdata = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [2:0] init_cfg = 3'h7;
   reg [1:0] sub_cfg = 2'h1;
   reg [1:0] mon_cfg = 2'h1;
   reg pll_lock_pin = 1'b1;
   reg clock_fail_pin = 1'b0;
   reg irq_event = 1'b0;
   reg remap_wr_req = 1'b0;
   reg [3:0] osc_cnt = 4'h0;
   wire [15:0] reg_rdata;
   wire [1:0] primary_submode;
   wire [2:0] current_source;
   wire pll_enable, pll_ref_primary, secondary_osc_enable, pin_remap_lock;
   wire remap_wr_accept, fosc_tick, cycle_tick, cpu_tick;
   integer bad_count = 0;
   integer n_tests = 0;
   integer i;
   integer t;
   reg [15:0] d;
   reg [31:0] rows [0:5];

   // Clock and oscillator square waves
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) osc_cnt <= osc_cnt + 4'h1;

   occd_clock_ctrl i_occd_clock_ctrl
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .initial_source_select_cfg(init_cfg), .primary_submode_cfg(sub_cfg),
      .switch_monitor_cfg(mon_cfg), .fast_rc_osc_pin(osc_cnt[1]),
      .low_power_rc_osc_pin(osc_cnt[3]), .secondary_osc_pin(osc_cnt[2]),
      .primary_osc_pin(osc_cnt[1]), .pll_out_pin(osc_cnt[1]),
      .pll_lock_pin(pll_lock_pin), .clock_fail_pin(clock_fail_pin),
      .irq_event(irq_event), .remap_wr_req(remap_wr_req), .pll_enable(pll_enable),
      .pll_ref_primary(pll_ref_primary), .secondary_osc_enable(secondary_osc_enable),
      .primary_submode(primary_submode), .current_source(current_source),
      .pin_remap_lock(pin_remap_lock), .remap_wr_accept(remap_wr_accept),
      .fosc_tick(fosc_tick), .cycle_tick(cycle_tick), .cpu_tick(cpu_tick)
   );

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task report_and_stop;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 d = reg_rdata;
      end
   endtask
   // Oscillator control write behind the two unlock keys
   task uwr(input [15:0] v);
      begin
         wr(`OCCD_ADDR_UNLOCK, `OCCD_UNLOCK_KEY1);
         wr(`OCCD_ADDR_UNLOCK, `OCCD_UNLOCK_KEY2);
         wr(`OCCD_ADDR_OSC_CTRL, v);
      end
   endtask
   // One-cycle pulse: 0 interrupt, 1 remap write, 2 clock fail
   task pulse(input [1:0] k);
      begin
         @(posedge clk_sys);
         {clock_fail_pin, remap_wr_req, irq_event} <= 3'h1 << k;
         @(posedge clk_sys);
         {clock_fail_pin, remap_wr_req, irq_event} <= 3'h0;
      end
   endtask
   // Bounded wait for the active source; t holds the cycles spent
   task wait_src(input [2:0] s);
      begin
         t = 0;
         while (current_source !== s && t < 300)
         begin
            @(posedge clk_sys);
            #1 t = t + 1;
         end
         if (current_source !== s)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t source switch timed out", $time);
            report_and_stop;
         end
      end
   endtask
   // Cycle ticks between two processor ticks, left in t; bounded
   task cpu_gap;
      integer k;
      begin
         t = 0;
         k = 0;
         while (cpu_tick !== 1'b1 && k < 600)
         begin
            @(posedge clk_sys);
            #1 k = k + 1;
         end
         @(posedge clk_sys);
         #1 k = k + 1;
         while (cpu_tick !== 1'b1 && k < 600)
         begin
            t = t + cycle_tick;
            @(posedge clk_sys);
            #1 k = k + 1;
         end
         if (cpu_tick !== 1'b1)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t processor tick timed out", $time);
            report_and_stop;
         end
      end
   endtask
   task do_reset;
      begin
         rst_n <= 1'b0;
         repeat (3) @(posedge clk_sys);
         rst_n <= 1'b1;
         repeat (2) @(posedge clk_sys);
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rows[0] = {16'h0700, 16'h0700};
      rows[1] = {16'h0800, 16'h0000};
      rows[2] = {16'h5800, 16'h5800};
      rows[3] = {16'h2800, 16'h5800};
      rows[4] = {16'h9500, 16'hd500};
      rows[5] = {16'hd800, 16'hd800};
      do_reset;
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h7700);
      rd(`OCCD_ADDR_CLK_DIV);
      chk(d, 16'h3000);
      rd(4'hc);
      chk(d, 16'h0000);
      $display("reset test done");
      // Clock divisor table
      for (i = 0; i < 6; i = i + 1)
      begin
         wr(`OCCD_ADDR_CLK_DIV, rows[i][31:16]);
         rd(`OCCD_ADDR_CLK_DIV);
         chk(d, rows[i][15:0]);
      end
      pulse(0);
      rd(`OCCD_ADDR_CLK_DIV);
      chk(d, 16'hd000);
      cpu_gap;
      chk(t[15:0], 16'h0001);
      wr(`OCCD_ADDR_CLK_DIV, 16'h5800);
      pulse(0);
      rd(`OCCD_ADDR_CLK_DIV);
      chk(d, 16'h5800);
      cpu_gap;
      chk(t[15:0], 16'h0020);
      $display("divisor test done");
      // Locked write, remap lock and secondary enable
      wr(`OCCD_ADDR_OSC_CTRL, 16'h0042);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h7700);
      pulse(1);
      #1 chk({15'h0000, remap_wr_accept}, 16'h0001);
      uwr(16'h0742);
      pulse(1);
      #1 chk({15'h0000, remap_wr_accept}, 16'h0000);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h7742);
      chk({15'h0000, secondary_osc_enable}, 16'h0001);
      // Request to the same source is dropped
      uwr(16'h0743);
      repeat (2) @(posedge clk_sys);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h7742);
      $display("control test done");
      // Switch to plain fast RC, then to primary with PLL
      uwr(16'h0043);
      wait_src(3'h0);
      chk({15'h0000, t >= 36}, 16'h0001);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h0042);
      uwr(16'h0343);
      wait_src(3'h3);
      chk({14'h0000, pll_enable, pll_ref_primary}, 16'h0003);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h3362);
      // Source lock blocks the next request
      uwr(16'h03c2);
      uwr(16'h00c3);
      repeat (60) @(posedge clk_sys);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h30e2);
      $display("switch test done");
      // Primary start with the fail-safe monitor on
      @(posedge clk_sys);
      init_cfg <= 3'h2;
      sub_cfg <= 2'h2;
      mon_cfg <= 2'h0;
      do_reset;
      chk({14'h0000, primary_submode}, 16'h0002);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h2200);
      pulse(2);
      repeat (8) @(posedge clk_sys);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h0208);
      uwr(16'h0200);
      rd(`OCCD_ADDR_OSC_CTRL);
      chk(d, 16'h0200);
      $display("fail test done");
      report_and_stop;
   end
endmodule // tb
